// ---- srg_map.vh ----
/*
 * Register map, field positions, reset values and divider limits of the
 * serial rate generator. Assumes inclusion by srg_rate_gen.v only.
 */
`ifndef SRG_MAP_VH
`define SRG_MAP_VH

// Byte offsets on the register bus
`define SRG_OFF_DIV_LOW    8'h00
`define SRG_OFF_DIV_HIGH   8'h04
`define SRG_OFF_RATE_CTRL  8'h08
`define SRG_OFF_TX_CTRL    8'h0C
`define SRG_OFF_COUNT      8'h10

// Register select codes
`define SRG_SEL_NONE       3'h0
`define SRG_SEL_DIV_LOW    3'h1
`define SRG_SEL_DIV_HIGH   3'h2
`define SRG_SEL_RATE_CTRL  3'h3
`define SRG_SEL_TX_CTRL    3'h4
`define SRG_SEL_COUNT      3'h5

// Rate control fields
`define SRG_RC_OVF_BIT     7
`define SRG_RC_IDLE_BIT    6
`define SRG_RC_WIDE_BIT    3
`define SRG_RC_WR_MASK     8'h1B

// Transmit control fields
`define SRG_TC_SYNC_BIT    4
`define SRG_TC_HS_BIT      2
`define SRG_TC_EMPTY_BIT   1
`define SRG_TC_WR_MASK     8'hFD

// Reset values
`define SRG_RST_DIV        8'h00
`define SRG_RST_RATE_CTRL  8'h00
`define SRG_RST_TX_CTRL    8'h00

// Prescaler limits: multiplier minus one
`define SRG_PRE_LIM_64     6'h3F
`define SRG_PRE_LIM_16     6'h0F
`define SRG_PRE_LIM_4      6'h03

`endif

// ---- srg_divider.v ----
/*
 * Free-running 16-bit divider with synchronous clear and a registered
 * wrap pulse. Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
module srg_divider (
    input  wire        clock,   // System clock
    input  wire        rst_n,   // Async reset, active low
    input  wire        clear,   // Restart from zero
    input  wire        enable,  // Count this cycle
    input  wire [15:0] limit,   // Last count before wrap
    output reg  [15:0] count_q, // Current count
    output reg         tick_q   // One-cycle wrap pulse
);

    // Compare with >= so a shrunken limit still wraps at once
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 16'h0000;
            tick_q  <= 1'b0;
        end else if (clear) begin
            count_q <= 16'h0000;
            tick_q  <= 1'b0;
        end else begin
            tick_q <= 1'b0;
            if (enable) begin
                if (count_q >= limit) begin
                    count_q <= 16'h0000;
                    tick_q  <= 1'b1;
                end else begin
                    count_q <= count_q + 16'h0001;
                end
            end
        end
    end

endmodule // srg_divider

// ---- srg_rate_gen.v ----
/*
 * Serial port rate timer with its APB register file. Produces a one-cycle
 * rate tick for the transmitter and receiver. Assumes an APB master on the
 * same clock, and receiver/transmitter status inputs on the same clock.
 */
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "srg_map.vh"
module srg_rate_gen (
    input  wire        clock,         // System clock, 125 MHz
    input  wire        rst_n,         // Async reset, active low
    input  wire        psel,          // APB select
    input  wire        penable,       // APB access phase
    input  wire        pwrite,        // APB write
    input  wire [7:0]  paddr,         // APB byte address
    input  wire [31:0] pwdata,        // APB write data
    output reg  [31:0] prdata,        // APB read data
    output reg         pready,        // APB ready
    output reg         pslverr,       // APB error, unmapped address
    input  wire        receiver_idle, // Receiver idle flag
    input  wire        autobaud_ovf,  // Auto-baud overflow flag
    input  wire        transmit_empty,// Transmit shifter empty
    output wire        rate_tick,     // One pulse per rate period
    output reg  [7:0]  rate_ctrl_q,   // Writable rate control bits
    output reg  [7:0]  tx_ctrl_q      // Writable transmit control bits
);

    reg  [7:0]  div_low_q;
    reg  [7:0]  div_high_q;
    reg  [5:0]  pre_lim;
    reg  [15:0] div_eff;
    reg  [7:0]  rd_byte;
    wire [2:0]  sel;
    wire        wr_go;
    wire        div_wr;
    wire        pre_tick;
    wire [15:0] pre_count;
    wire [15:0] rate_count;
    wire        sync_mode;
    wire        high_speed_select;
    wire        wide_counter_select;

    // Address decode, shared by the read and write paths
    function [2:0] reg_sel;
        input [7:0] addr;
        begin
            case (addr)
                `SRG_OFF_DIV_LOW:   reg_sel = `SRG_SEL_DIV_LOW;
                `SRG_OFF_DIV_HIGH:  reg_sel = `SRG_SEL_DIV_HIGH;
                `SRG_OFF_RATE_CTRL: reg_sel = `SRG_SEL_RATE_CTRL;
                `SRG_OFF_TX_CTRL:   reg_sel = `SRG_SEL_TX_CTRL;
                `SRG_OFF_COUNT:     reg_sel = `SRG_SEL_COUNT;
                default:            reg_sel = `SRG_SEL_NONE;
            endcase
        end
    endfunction

    assign sel = reg_sel(paddr);

    // Write lands only at the access edge where pready is high
    assign wr_go  = psel & penable & pready & pwrite;
    assign div_wr = wr_go & ((sel == `SRG_SEL_DIV_LOW) | (sel == `SRG_SEL_DIV_HIGH));

    // Mode bits
    assign sync_mode           = tx_ctrl_q[`SRG_TC_SYNC_BIT];
    assign high_speed_select   = tx_ctrl_q[`SRG_TC_HS_BIT];
    assign wide_counter_select = rate_ctrl_q[`SRG_RC_WIDE_BIT];

    // Multiplier choice; high speed is a don't-care in sync mode
    always @* begin
        if (sync_mode) begin
            pre_lim = `SRG_PRE_LIM_4;
        end else begin
            case ({wide_counter_select, high_speed_select})
                2'b00:   pre_lim = `SRG_PRE_LIM_64;
                2'b01:   pre_lim = `SRG_PRE_LIM_16;
                2'b10:   pre_lim = `SRG_PRE_LIM_16;
                2'b11:   pre_lim = `SRG_PRE_LIM_4;
                default: pre_lim = `SRG_PRE_LIM_64;
            endcase
        end
    end

    // Divisor width: high byte only counts in wide mode
    always @* begin
        if (wide_counter_select) begin
            div_eff = {div_high_q, div_low_q};
        end else begin
            div_eff = {8'h00, div_low_q};
        end
    end

    // Prescaler divides the clock by the multiplier
    srg_divider u_prescale (
        .clock   (clock),
        .rst_n   (rst_n),
        .clear   (div_wr),
        .enable  (1'b1),
        .limit   ({10'h000, pre_lim}),
        .count_q (pre_count),
        .tick_q  (pre_tick)
    );

    // Rate counter divides prescaler pulses by n+1, never stops
    srg_divider u_rate (
        .clock   (clock),
        .rst_n   (rst_n),
        .clear   (div_wr),
        .enable  (pre_tick),
        .limit   (div_eff),
        .count_q (rate_count),
        .tick_q  (rate_tick)
    );

    // Software registers; unmapped writes are dropped
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_low_q   <= `SRG_RST_DIV;
            div_high_q  <= `SRG_RST_DIV;
            rate_ctrl_q <= `SRG_RST_RATE_CTRL;
            tx_ctrl_q   <= `SRG_RST_TX_CTRL;
        end else if (wr_go) begin
            case (sel)
                `SRG_SEL_DIV_LOW:   div_low_q   <= pwdata[7:0];
                `SRG_SEL_DIV_HIGH:  div_high_q  <= pwdata[7:0];
                `SRG_SEL_RATE_CTRL: rate_ctrl_q <= pwdata[7:0] & `SRG_RC_WR_MASK;
                `SRG_SEL_TX_CTRL:   tx_ctrl_q   <= pwdata[7:0] & `SRG_TC_WR_MASK;
                default:            div_low_q   <= div_low_q;
            endcase
        end
    end

    // Read mux; status bits come live from the partner logic
    always @* begin
        case (sel)
            `SRG_SEL_DIV_LOW:   rd_byte = div_low_q;
            `SRG_SEL_DIV_HIGH:  rd_byte = div_high_q;
            `SRG_SEL_RATE_CTRL: rd_byte = rate_ctrl_q |
                                          ({7'h00, autobaud_ovf} << `SRG_RC_OVF_BIT) |
                                          ({7'h00, receiver_idle} << `SRG_RC_IDLE_BIT);
            `SRG_SEL_TX_CTRL:   rd_byte = tx_ctrl_q |
                                          ({7'h00, transmit_empty} << `SRG_TC_EMPTY_BIT);
            default:            rd_byte = 8'h00;
        endcase
    end

    // No wait state: every bus output is on a flop loaded in the setup cycle
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (psel & ~penable) begin
            pready  <= 1'b1;
            pslverr <= (sel == `SRG_SEL_NONE);
            if (sel == `SRG_SEL_COUNT) begin
                prdata <= {16'h0000, rate_count};
            end else begin
                prdata <= {24'h000000, rd_byte};
            end
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule // srg_rate_gen

// ---- srg_rate_gen_chk.sv ----
/* Port checker for srg_rate_gen: bus answer timing, tick spacing, restart, control masks.
   Assumes the default register offsets and the bind below. */
`timescale 1ns/1ps
module srg_chk (
    input wire        clock,       // Clock
    input wire        rst_n,       // Reset
    input wire        psel,        // Select
    input wire        penable,     // Access
    input wire        pwrite,      // Write
    input wire [7:0]  paddr,       // Address
    input wire [31:0] pwdata,      // Write data
    input wire        pready,      // Ready
    input wire        pslverr,     // Error
    input wire        rate_tick,   // Rate pulse
    input wire [7:0]  rate_ctrl_q, // Rate control
    input wire [7:0]  tx_ctrl_q    // Transmit control
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Write landing at this edge
    wire wr = psel && penable && pready && pwrite;
    setup_ready_a: assert property (psel && !penable |=> pready) else $error("no answer after setup");
    ready_one_a: assert property (pready |=> !pready) else $error("ready held too long");
    err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
    bad_write_a: assert property (wr && pslverr |=> $stable(rate_ctrl_q) && $stable(tx_ctrl_q))
        else $error("refused write changed control");
    tick_gap_a: assert property (rate_tick |=> !rate_tick [*3]) else $error("ticks too close");
    // Skip the cycle after the write, though the clear already zeroes the tick at the write edge
    div_clear_a: assert property (wr && (paddr == 8'h00 || paddr == 8'h04) |-> ##2 !rate_tick [*3])
        else $error("tick soon after restart");
    rc_mask_a: assert property (wr && paddr == 8'h08 |=> {24'h0, rate_ctrl_q} == ($past(pwdata) & 32'h1B))
        else $error("rate control write wrong");
    tc_mask_a: assert property (wr && paddr == 8'h0C |=> {24'h0, tx_ctrl_q} == ($past(pwdata) & 32'hFD))
        else $error("transmit control write wrong");
endmodule // srg_chk

bind srg_rate_gen srg_chk u_srg_chk (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .rate_tick(rate_tick), .rate_ctrl_q(rate_ctrl_q), .tx_ctrl_q(tx_ctrl_q));

// ---- srg_rate_gen_tb.sv ----
/* Self-checking bench for srg_rate_gen: APB register access and tick period per mode.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ps
module srg_rate_gen_tb;
    reg         clock, rst_n, psel, penable, pwrite, er;
    reg         receiver_idle, autobaud_ovf, transmit_empty;
    reg  [7:0]  paddr;
    reg  [31:0] pwdata, rd;
    wire [31:0] prdata;
    wire        pready, pslverr, rate_tick;
    wire [7:0]  rate_ctrl_q, tx_ctrl_q;
    integer     bad_count, n_checks, c;
    srg_rate_gen u_srg_rate_gen (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .receiver_idle(receiver_idle), .autobaud_ovf(autobaud_ovf), .transmit_empty(transmit_empty),
        .rate_tick(rate_tick), .rate_ctrl_q(rate_ctrl_q), .tx_ctrl_q(tx_ctrl_q));
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", n_checks, bad_count);
            if (bad_count == 0 && n_checks > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] exp, input [31:0] got);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("mismatch %0s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    // One APB transfer; held until pready is sampled high
    task apb(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge clock);
            psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
            @(posedge clock);
            penable <= 1'b1;
            c = 0;
            do begin
                @(posedge clock);
                c = c + 1;
            end while (pready !== 1'b1 && c < 20);
            if (c >= 20) begin bad_count = bad_count + 1; finish_test; end
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    // Cycles until the next tick; the bound covers the slowest mode used
    task tick(output integer n);
        begin
            n = 0;
            do begin
                @(posedge clock);
                #1 n = n + 1;
            end while (rate_tick !== 1'b1 && n < 20000);
            if (n >= 20000) begin bad_count = bad_count + 1; finish_test; end
        end
    endtask
    task t_default;
        begin
            tick(c);
            tick(c);
            chk("period", 32'h40, c);
        end
    endtask
    // Reset values, masks, live status bits, refused address
    task t_regs;
        begin
            apb(1'b0, 8'h08, 32'h0); chk("rc_rst", 32'h40, rd);
            apb(1'b0, 8'h0C, 32'h0); chk("tc_rst", 32'h02, rd);
            autobaud_ovf <= 1'b1; receiver_idle <= 1'b0; transmit_empty <= 1'b0;
            apb(1'b1, 8'h08, 32'hFF); apb(1'b0, 8'h08, 32'h0); chk("rc_rw", 32'h9B, rd);
            apb(1'b1, 8'h0C, 32'hFF); apb(1'b0, 8'h0C, 32'h0); chk("tc_rw", 32'hFD, rd);
            apb(1'b1, 8'h04, 32'h1234_56A5); apb(1'b0, 8'h04, 32'h0); chk("div_hi", 32'hA5, rd);
            apb(1'b1, 8'h20, 32'hFF); chk("err", 32'h1, {31'h0, er});
            apb(1'b0, 8'h20, 32'h0); chk("err_rd", 32'h0, rd);
            // Count register is read-only: a write is dropped without an error
            apb(1'b1, 8'h10, 32'hFF); chk("cnt_wr_err", 32'h0, {31'h0, er});
        end
    endtask
    // All sync, wide and high-speed combinations; divisor rewrite restarts the timer
    task t_modes;
        integer i, p;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                apb(1'b1, 8'h04, 32'h01);
                apb(1'b1, 8'h08, {i[1], 3'h0});
                apb(1'b1, 8'h0C, {i[2], 1'b0, i[0], 2'h0});
                apb(1'b1, 8'h00, 32'h02);
                tick(c);
                tick(c);
                p = (i[2] ? 32'h4 : i[1] ? (i[0] ? 32'h4 : 32'h10) : (i[0] ? 32'h10 : 32'h40)) * (i[1] ? 32'h103 : 32'h3);
                apb(1'b1, 8'h00, 32'h02);
                tick(c); chk("first", p + 1, c);
                tick(c); chk("period", p, c);
                // Slow 8-bit mode: mid-period the rate count stands at 1 for 64 cycles
                if (i == 0) begin
                    repeat (100) @(posedge clock);
                    apb(1'b0, 8'h10, 32'h0);
                    chk("count", 32'h1, rd);
                end
            end
        end
    endtask
    // Free-running 125 MHz clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // Reset for 8 cycles, then the scenarios
    initial begin
        rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
        receiver_idle = 1'b1; autobaud_ovf = 1'b0; transmit_empty = 1'b1; bad_count = 0; n_checks = 0;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        t_default;
        t_regs;
        t_modes;
        finish_test;
    end
endmodule // srg_rate_gen_tb
